// ### verilog/asq_pkg.sv
// asq_pkg: register map, field positions, reset values
// and conversion timing for the converter sequencer.
// assumes word-aligned apb offsets on an 8-bit paddr.
package asq_pkg;

    // register byte offsets
    localparam logic [7:0] CTRL1_OFS = 8'h00;
    localparam logic [7:0] CTRL2_OFS = 8'h04;
    localparam logic [7:0] RESL_OFS  = 8'h08;
    localparam logic [7:0] RESH_OFS  = 8'h0C;

    // control one fields
    localparam int GO_BIT  = 7;
    localparam int MODE_HI = 5;
    localparam int MODE_LO = 4;
    localparam int AIN_BIT = 3;
    localparam int CH_HI   = 2;
    localparam int CH_LO   = 0;

    // control two fields
    localparam int DONE_BIT = 7;
    localparam int BUSY_BIT = 6;
    localparam int CT_HI    = 2;
    localparam int CT_LO    = 0;

    // widths and reset values
    localparam int RES_W = 10;
    localparam int CNT_W = 11;
    localparam logic [2:0]  CT_RST  = 3'h0;
    localparam logic [2:0]  CH_RST  = 3'h0;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // conversion length is base cycles shifted by the code
    localparam logic [CNT_W-1:0] CONV_BASE_CYC = 11'h027;
    localparam logic [2:0]       CT_MAX_CODE   = 3'h5;

    // operating modes, codes fixed by software
    typedef enum logic [1:0] {
        MODE_OFF    = 2'b00,
        MODE_SINGLE = 2'b01,
        MODE_RSVD   = 2'b10,
        MODE_REPEAT = 2'b11
    } asq_mode_t;

    // timer states
    typedef enum logic {TS_IDLE, TS_RUN} asq_tstate_t;

    // reserved codes fall back to the longest length
    function automatic logic [CNT_W-1:0] conv_len(input logic [2:0] code);
        logic [2:0] c;
        c = (code > CT_MAX_CODE) ? CT_MAX_CODE : code;
        conv_len = CONV_BASE_CYC << c;
    endfunction : conv_len

endpackage : asq_pkg

// ### verilog/asq_tmr_if.sv
// asq_tmr_if: carries start, abort and length select to
// the conversion timer and its done and busy back.
// assumes both ends share i_clk.
`timescale 1ns/1ps
`default_nettype none
interface asq_tmr_if;
    logic       start;
    logic       abort;
    logic [2:0] sel;
    logic       done;
    logic       busy;

    modport ctl (output start, output abort, output sel,
                 input done, input busy);
    modport tmr (input start, input abort, input sel,
                 output done, output busy);
endinterface : asq_tmr_if
`default_nettype wire

// ### verilog/asq_timer.sv
// asq_timer: counts clock cycles of one conversion.
// assumes start is only raised when idle or on done.
`timescale 1ns/1ps
`default_nettype none
module asq_timer (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_nrst,
    // control side
    asq_tmr_if.tmr    tif
);

    asq_pkg::asq_tstate_t            state_r;
    logic [asq_pkg::CNT_W-1:0]       cnt_r;
    logic [asq_pkg::CNT_W-1:0]       len_w;
    logic                            last_w;

    ////////////////////////////////////////////////////////////
    // length decode and completion
    assign len_w  = asq_pkg::conv_len(tif.sel);
    assign last_w = (cnt_r == len_w - 11'h001);
    // abort masks completion so a halted result is never stored
    assign tif.done = (state_r == asq_pkg::TS_RUN) && last_w && !tif.abort;
    assign tif.busy = (state_r == asq_pkg::TS_RUN);

    ////////////////////////////////////////////////////////////
    // state and counter
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= asq_pkg::TS_IDLE;
            cnt_r   <= '0;
        end else if (tif.abort) begin
            state_r <= asq_pkg::TS_IDLE;
            cnt_r   <= '0;
        end else begin
            unique case (state_r)
                asq_pkg::TS_IDLE: begin
                    if (tif.start) begin
                        state_r <= asq_pkg::TS_RUN;
                    end
                    cnt_r <= '0;
                end
                asq_pkg::TS_RUN: begin
                    if (last_w) begin
                        state_r <= tif.start ? asq_pkg::TS_RUN : asq_pkg::TS_IDLE;
                        cnt_r   <= '0;
                    end else begin
                        cnt_r <= cnt_r + 11'h001;
                    end
                end
            endcase
        end
    end

endmodule : asq_timer
`default_nettype wire

// ### verilog/asq_seq.sv
// asq_seq: apb register file and sequencing for a 10-bit
// converter with single and repeat modes.
// assumes the analog core presents a settled result on
// i_conv_data whenever the conversion timer completes.
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module asq_seq (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // power manager
    input  wire logic        i_low_power,
    // analog core
    input  wire logic [9:0]  i_conv_data,
    output logic [2:0]       o_channel_select,
    output logic             o_analog_input_enable,
    output logic             o_vref_connect,
    output logic             o_sample_start,
    output logic             o_converter_busy,
    // interrupt controller
    output logic             o_conversion_done_irq
);

    ////////////////////////////////////////////////////////////
    // address decode, one-hot over the four registers
    function automatic logic [3:0] reg_hit(input logic [7:0] a);
        reg_hit = {a == asq_pkg::RESH_OFS,
                   a == asq_pkg::RESL_OFS,
                   a == asq_pkg::CTRL2_OFS,
                   a == asq_pkg::CTRL1_OFS};
    endfunction : reg_hit

    // register state
    logic                      go_r;
    asq_pkg::asq_mode_t        mode_r;
    logic                      ain_r;
    logic [2:0]                ch_r;
    logic [2:0]                ct_r;
    logic                      done_r;
    logic [asq_pkg::RES_W-1:0] res_r;
    logic                      lowpend_r;
    logic                      ack_r;
    logic [31:0]               prdata_r;

    // next values
    logic                      go_nxt;
    asq_pkg::asq_mode_t        mode_nxt;
    logic                      ain_nxt;
    logic [2:0]                ch_nxt;
    logic [2:0]                ct_nxt;
    logic                      done_nxt;
    logic [asq_pkg::RES_W-1:0] res_nxt;
    logic                      lowpend_nxt;
    logic [31:0]               prdata_nxt;

    // decode and event wires
    logic [3:0]  hit_w;
    logic        acc_first_w;
    logic        wr_w;
    logic        rd_w;
    logic        wr_c1_w;
    logic        wr_c2_w;
    logic        rd_resl_w;
    logic        rd_resh_w;
    logic        wr_off_w;
    logic        mode_ok_w;
    logic        repeat_w;
    logic        start_w;
    logic        restart_w;
    logic        halt_w;
    logic        clr_all_w;
    logic        discard_w;
    logic        store_w;
    logic [7:0]  c1_rd_w;
    logic [7:0]  c2_rd_w;
    logic [7:0]  resh_rd_w;

    asq_tmr_if tif ();

    ////////////////////////////////////////////////////////////
    // apb phases: read data captured in the first access cycle, writes in the second,
    // pready one cycle later so prdata comes from a flop
    assign hit_w       = reg_hit(i_paddr);
    assign acc_first_w = i_psel && i_penable && !ack_r;
    assign wr_w        = ack_r && i_psel && i_penable && i_pwrite;
    assign rd_w        = acc_first_w && !i_pwrite;
    assign o_pready    = ack_r;
    assign o_pslverr   = ack_r && (hit_w == 4'h0);
    assign o_prdata    = prdata_r;

    // writes are ignored while asleep so nothing restarts
    assign wr_c1_w   = wr_w && hit_w[0] && !i_low_power;
    assign wr_c2_w   = wr_w && hit_w[1] && !i_low_power;
    assign rd_resl_w = rd_w && hit_w[2];
    assign rd_resh_w = rd_w && hit_w[3];

    ////////////////////////////////////////////////////////////
    // sequencing decisions
    assign wr_off_w  = wr_c1_w &&
                       (i_pwdata[asq_pkg::MODE_HI:asq_pkg::MODE_LO] == asq_pkg::MODE_OFF);
    assign mode_ok_w = (mode_r == asq_pkg::MODE_SINGLE) ||
                       (mode_r == asq_pkg::MODE_REPEAT);
    assign repeat_w  = (mode_r == asq_pkg::MODE_REPEAT);

    // halt covers a mode-off write, a standing off mode and sleep
    assign halt_w    = i_low_power || wr_off_w ||
                       (mode_r == asq_pkg::MODE_OFF);
    assign clr_all_w = halt_w;

    // go only acts when idle and a conversion mode is chosen
    assign start_w   = go_r && mode_ok_w && !tif.busy && !halt_w;
    assign restart_w = tif.done && repeat_w;

    // in repeat mode, a completion landing between the two byte reads is lost
    assign discard_w = tif.done && repeat_w && lowpend_r;
    assign store_w   = tif.done && !discard_w;

    ////////////////////////////////////////////////////////////
    // timer hookup
    assign tif.start = start_w || restart_w;
    assign tif.abort = halt_w;
    assign tif.sel   = ct_r;

    asq_timer u_timer (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .tif    (tif)
    );

    ////////////////////////////////////////////////////////////
    // readback images; unused bits read zero
    assign c1_rd_w   = {go_r, 1'b0, mode_r, ain_r, ch_r};
    assign c2_rd_w   = {done_r, tif.busy, 3'b000, ct_r};
    assign resh_rd_w = {6'b00_0000, res_r[9:8]};

    always_comb begin
        prdata_nxt = prdata_r;
        if (acc_first_w) begin
            unique case (1'b1)
                hit_w[0]: prdata_nxt = {24'h00_0000, c1_rd_w};
                hit_w[1]: prdata_nxt = {24'h00_0000, c2_rd_w};
                hit_w[2]: prdata_nxt = {24'h00_0000, res_r[7:0]};
                hit_w[3]: prdata_nxt = {24'h00_0000, resh_rd_w};
                default:  prdata_nxt = asq_pkg::RD_ZERO;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////
    // control one: go clears once the conversion has begun,
    // or at once if no conversion mode is selected
    always_comb begin
        go_nxt   = go_r;
        mode_nxt = mode_r;
        ain_nxt  = ain_r;
        ch_nxt   = ch_r;
        if (start_w || !mode_ok_w) begin
            go_nxt = 1'b0;
        end
        if (wr_c1_w) begin
            go_nxt   = i_pwdata[asq_pkg::GO_BIT];
            mode_nxt = asq_pkg::asq_mode_t'(i_pwdata[asq_pkg::MODE_HI:asq_pkg::MODE_LO]);
            ain_nxt  = i_pwdata[asq_pkg::AIN_BIT];
            ch_nxt   = i_pwdata[asq_pkg::CH_HI:asq_pkg::CH_LO];
        end
        if (i_low_power) begin
            go_nxt   = 1'b0;
            mode_nxt = asq_pkg::MODE_OFF;
            ain_nxt  = 1'b0;
        end
    end

    // control two: only the time select is writable
    assign ct_nxt = wr_c2_w ? i_pwdata[asq_pkg::CT_HI:asq_pkg::CT_LO] : ct_r;

    ////////////////////////////////////////////////////////////
    // done flag: a completion wins over a same-cycle clear
    always_comb begin
        if (clr_all_w) begin
            done_nxt = 1'b0;
        end else if (store_w) begin
            done_nxt = 1'b1;
        end else if (rd_resh_w) begin
            done_nxt = 1'b0;
        end else if (start_w) begin
            done_nxt = 1'b0;
        end else begin
            done_nxt = done_r;
        end
    end

    // result bytes keep the old value until a stored completion, or clear to zero on a halt
    always_comb begin
        if (clr_all_w) begin
            res_nxt = '0;
        end else if (store_w) begin
            res_nxt = i_conv_data;
        end else begin
            res_nxt = res_r;
        end
    end

    // in repeat mode a low byte read opens the window that protects the pair
    always_comb begin
        if (clr_all_w || rd_resh_w) begin
            lowpend_nxt = 1'b0;
        end else if (rd_resl_w && repeat_w) begin
            lowpend_nxt = 1'b1;
        end else begin
            lowpend_nxt = lowpend_r;
        end
    end

    ////////////////////////////////////////////////////////////
    // register update
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            go_r      <= 1'b0;
            mode_r    <= asq_pkg::MODE_OFF;
            ain_r     <= 1'b0;
            ch_r      <= asq_pkg::CH_RST;
            ct_r      <= asq_pkg::CT_RST;
            done_r    <= 1'b0;
            res_r     <= '0;
            lowpend_r <= 1'b0;
            ack_r     <= 1'b0;
            prdata_r  <= asq_pkg::RD_ZERO;
        end else begin
            go_r      <= go_nxt;
            mode_r    <= mode_nxt;
            ain_r     <= ain_nxt;
            ch_r      <= ch_nxt;
            ct_r      <= ct_nxt;
            done_r    <= done_nxt;
            res_r     <= res_nxt;
            lowpend_r <= lowpend_nxt;
            ack_r     <= acc_first_w;
            prdata_r  <= prdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////
    // analog core and interrupt outputs
    assign o_channel_select      = ch_r;
    assign o_analog_input_enable = ain_r;
    // reference drops the moment sleep is requested, even mid-conversion
    assign o_vref_connect        = ain_r && !i_low_power;
    assign o_sample_start        = tif.start && !halt_w;
    assign o_converter_busy      = tif.busy;
    // pulse coincides with the edge that sets done
    assign o_conversion_done_irq = store_w;

endmodule : asq_seq
`default_nettype wire

// ### verification/asq_seq_sva.sv
// asq_seq_sva: port-level timing checks of the converter sequencer.
// assumes it is bound onto asq_seq; one clock domain only.
`timescale 1ns/1ps
`default_nettype none
module asq_seq_sva (
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_nrst,
    // apb slave side
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    // core and power side
    input wire logic        i_low_power,
    input wire logic        o_vref_connect,
    input wire logic        o_sample_start,
    input wire logic        o_converter_busy,
    input wire logic        o_conversion_done_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    ////////////////////////////////////////////////////////////////
    // any offset outside the four words must answer with an error
    wire logic unmapped = !(i_paddr inside {asq_pkg::CTRL1_OFS, asq_pkg::CTRL2_OFS,
                                            asq_pkg::RESL_OFS, asq_pkg::RESH_OFS});
    // bus steps: setup, then one wait state, then the answer
    sequence s_setup; i_psel && !i_penable; endsequence
    sequence s_ack; !o_pready ##1 o_pready; endsequence
    property p_apb_wait; s_setup |=> s_ack; endproperty
    property p_ready_pulse; o_pready |=> !o_pready; endproperty
    property p_slverr; o_pready |-> (o_pslverr == unmapped); endproperty
    property p_high_zero; o_pready && !i_pwrite && i_paddr == asq_pkg::RESH_OFS |-> o_prdata[31:2] == 30'h0; endproperty
    property p_irq_pulse; o_conversion_done_irq |=> !o_conversion_done_irq; endproperty
    property p_irq_busy; o_conversion_done_irq |-> o_converter_busy; endproperty
    property p_start_busy; o_sample_start && !i_psel && !i_low_power |=> o_converter_busy; endproperty
    // a stop write or power-down may cut the shortest conversion short
    property p_busy_hold; $rose(o_converter_busy) |-> (o_converter_busy || i_low_power || i_psel)[*8]; endproperty
    property p_lp_abort; i_low_power |=> !o_converter_busy && !o_vref_connect; endproperty
    property p_wake_idle; $fell(i_low_power) |-> (!o_converter_busy && !o_sample_start)[*3]; endproperty
    ////////////////////////////////////////////////////////////////
    a_apb_wait: assert property (p_apb_wait) else $error("pready not after one wait state");
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held two cycles");
    a_slverr: assert property (p_slverr) else $error("pslverr does not match address decode");
    a_high_zero: assert property (p_high_zero) else $error("high result upper bits not zero");
    a_irq_pulse: assert property (p_irq_pulse) else $error("done interrupt longer than one cycle");
    a_irq_busy: assert property (p_irq_busy) else $error("done interrupt outside busy");
    a_start_busy: assert property (p_start_busy) else $error("busy not set after start");
    a_busy_hold: assert property (p_busy_hold) else $error("conversion ended too early");
    a_lp_abort: assert property (p_lp_abort) else $error("low power did not abort");
    a_wake_idle: assert property (p_wake_idle) else $error("converter resumed after wake");
endmodule : asq_seq_sva
bind asq_seq asq_seq_sva u_sva (.i_clk(i_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_low_power(i_low_power), .o_vref_connect(o_vref_connect), .o_sample_start(o_sample_start),
    .o_converter_busy(o_converter_busy), .o_conversion_done_irq(o_conversion_done_irq));
`default_nettype wire

// ### verification/asq_seq_tb_top.sv
// asq_seq_tb_top: directed apb test of the converter sequencer.
// assumes the checker is bound in; the bench stands in for the core.
`timescale 1ns/1ps
`default_nettype none
module asq_seq_tb_top;
    logic        i_clk, i_nrst, i_psel, i_penable, i_pwrite, i_low_power, err, irq_seen;
    logic [7:0]  i_paddr;
    logic [31:0] i_pwdata, o_prdata, q;
    logic [9:0]  i_conv_data, d;
    logic [2:0]  o_channel_select;
    logic        o_pready, o_pslverr, o_analog_input_enable, o_vref_connect;
    logic        o_sample_start, o_converter_busy, o_conversion_done_irq;
    int          error_cnt, samples_checked, cyc, n;
    // control one value: input enabled, channel 3
    localparam logic [7:0] CFG = 8'h0B;
    asq_seq uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_low_power(i_low_power), .i_conv_data(i_conv_data), .o_channel_select(o_channel_select),
        .o_analog_input_enable(o_analog_input_enable), .o_vref_connect(o_vref_connect),
        .o_sample_start(o_sample_start), .o_converter_busy(o_converter_busy),
        .o_conversion_done_irq(o_conversion_done_irq));
    ////////////////////////////////////////////////////////////////
    // clock, interrupt watch and hang guard
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (o_conversion_done_irq === 1'b1) irq_seen <= 1'b1;
        if (cyc == 40000) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, cyc, 0);
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // one apb transfer; an idle edge first keeps psel from being set twice in a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= v;
        @(posedge i_clk);
        i_penable <= 1'b1;
        @(posedge i_clk);
        while (o_pready !== 1'b1) @(posedge i_clk);
        q = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        apb(1'b1, a, {24'h00_0000, v});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, {24'h00_0000, e});
    endtask : rd
    task automatic wait_irq;
        do @(posedge i_clk); while (o_conversion_done_irq !== 1'b1);
    endtask : wait_irq
    task end_sim;
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////
    initial begin
        {i_nrst, i_psel, i_penable, i_pwrite, i_low_power, irq_seen} = 6'h0;
        {i_paddr, i_pwdata, i_conv_data} = 50'h0;
        repeat (6) @(posedge i_clk);
        i_nrst <= 1'b1;
        rd(asq_pkg::CTRL2_OFS, 8'h00);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(q, 32'h0);
        // single shots over time codes 0 to 6, reserved code 6 included
        for (int c = 0; c < 7; c++) begin
            d = 10'h2A5 + 10'(c);
            i_conv_data <= d;
            wr(asq_pkg::CTRL2_OFS, 8'(c));
            wr(asq_pkg::CTRL1_OFS, CFG | 8'h10);
            wr(asq_pkg::CTRL1_OFS, CFG | 8'h90);
            do @(posedge i_clk); while (o_sample_start !== 1'b1);
            n = 0;
            do begin
                @(posedge i_clk);
                n++;
            end while (o_conversion_done_irq !== 1'b1);
            chk(n, (c > 5) ? 1248 : (39 << c));
            rd(asq_pkg::CTRL1_OFS, CFG | 8'h10);
            chk({29'h0, o_channel_select}, 32'h3);
            chk({31'h0, o_analog_input_enable}, 32'h1);
            rd(asq_pkg::CTRL2_OFS, 8'h80 | 8'(c));
            rd(asq_pkg::RESL_OFS, d[7:0]);
            rd(asq_pkg::RESH_OFS, {6'h0, d[9:8]});
            rd(asq_pkg::CTRL2_OFS, 8'(c));
        end
        // retrigger without reading the high byte
        wr(asq_pkg::CTRL2_OFS, 8'h00);
        i_conv_data <= 10'h155;
        wr(asq_pkg::CTRL1_OFS, CFG | 8'h90);
        wait_irq();
        i_conv_data <= 10'h0AA;
        wr(asq_pkg::CTRL1_OFS, CFG | 8'h90);
        rd(asq_pkg::CTRL2_OFS, 8'h40);
        rd(asq_pkg::RESL_OFS, 8'h55);
        wait_irq();
        rd(asq_pkg::RESL_OFS, 8'hAA);
        // repeat mode, a completion lands between the two byte reads
        i_conv_data <= 10'h3C3;
        wr(asq_pkg::CTRL1_OFS, CFG | 8'hB0);
        wait_irq();
        rd(asq_pkg::RESL_OFS, 8'hC3);
        i_conv_data <= 10'h03C;
        irq_seen <= 1'b0;
        repeat (45) @(posedge i_clk);
        chk({31'h0, irq_seen}, 32'h0);
        rd(asq_pkg::RESH_OFS, 8'h03);
        wait_irq();
        rd(asq_pkg::RESL_OFS, 8'h3C);
        // stop in mid-run clears flags and result
        wr(asq_pkg::CTRL1_OFS, CFG);
        @(posedge i_clk);
        chk({31'h0, o_converter_busy}, 32'h0);
        rd(asq_pkg::CTRL2_OFS, 8'h00);
        rd(asq_pkg::RESL_OFS, 8'h00);
        rd(asq_pkg::RESH_OFS, 8'h00);
        // reserved mode code: go is dropped and nothing starts
        wr(asq_pkg::CTRL1_OFS, CFG | 8'hA0);
        rd(asq_pkg::CTRL1_OFS, CFG | 8'h20);
        chk({31'h0, o_converter_busy}, 32'h0);
        // power-down during a conversion, writes refused meanwhile
        wr(asq_pkg::CTRL1_OFS, CFG | 8'h90);
        repeat (20) @(posedge i_clk);
        i_low_power <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk({31'h0, o_converter_busy}, 32'h0);
        chk({31'h0, o_vref_connect}, 32'h0);
        chk({31'h0, o_analog_input_enable}, 32'h0);
        wr(asq_pkg::CTRL1_OFS, CFG | 8'h90);
        rd(asq_pkg::CTRL1_OFS, 8'h03);
        rd(asq_pkg::CTRL2_OFS, 8'h00);
        i_low_power <= 1'b0;
        irq_seen <= 1'b0;
        repeat (60) @(posedge i_clk);
        chk({31'h0, irq_seen | o_converter_busy}, 32'h0);
        rd(asq_pkg::RESL_OFS, 8'h00);
        end_sim();
    end
endmodule : asq_seq_tb_top
`default_nettype wire
